//--- dpw_decoder.sv
// Behaviour
// - Index word is two bytes; only its low byte selects the array element.
// - Value block is two 16-bit words; meaning follows the command field.
// - Read request answers with the parameter's present value.
// - Enumerated options travel as the option number and are stored as such.
// - Text messages have variable length, given in the length byte.
// - Index character tells text read from text write.
// - Text read allowed only for data type 9.
// - Type codes 3,4,5,6,7,9; unsigned values carry no sign.
// - Values travel as integers scaled by the conversion factor.
// - Conversion index 2..-5 gives powers of ten; index 73 gives 0.1.
// - Error-code array read returns a fault code 1 to 99.
// - Process words: control then reference in, status then frequency out.
// - Control word layout used only when message profile is option 1.
// - Control bits 01..00 select preset reference 1 to 4.
// - Selections combine preset, DC brake and coast bits with inputs.
// - Bit 02 low requests DC braking and stop.
// - Bit 03 low shuts off the output stage; motor coasts.
// - Bit 04 low ramps down with the quick-stop ramp.
// - Bit 05 low freezes present output frequency.
// - Bits 06 to 15 carry start, reset, jog, ramp, valid, outputs, setup, reverse.
// - Key bits 15..12 carry the command codes.
// - Replies 0001 word, 0010 double, 1111 text, 0111 with fault number.
// - Key bits 10..0 carry the parameter number.
// - Parameter message data block is 12 bytes.
`timescale 1ns/10ps
`include "dpw_regs.svh"
module dpw_decoder
   import dpw_pkg::*;
(
   // Clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // Message from framing logic
   input  wire dpw_msg_type   msg_in,
   input  wire logic          msg_valid,
   input  wire logic          msg_ok,
   // Digital input functions
   input  wire logic [1:0]    din_preset,
   input  wire logic          din_dc_brake,
   input  wire logic          din_coast,
   // Reply and drive commands
   output dpw_msg_type        rsp,
   output logic               rsp_valid,
   output dpw_drive_type      drive,
   output logic               persist_req
);

   localparam int NP = `DPW_NUM_PARAMS;

   //----------------------------------------
   // Storage
   //----------------------------------------
   dpw_state_type state_reg;
   dpw_msg_type   msg_reg;
   dpw_attr_type  attr_reg [NP];
   logic [31:0]   pval_reg [NP];
   logic [7:0]    err_reg  [NP];
   logic [31:0]   ctrl_reg;
   logic [15:0]   status_reg;
   logic [15:0]   freq_reg;
   logic [15:0]   cw_reg;
   logic [15:0]   ref_reg;
   logic          cw7_prev_reg;
   logic [3:0]    ltype_reg;
   logic [10:0]   lnum_reg;
   logic [7:0]    lexp_reg;
   logic [31:0]   prdata_reg;
   logic          pready_reg;
   logic          pslverr_reg;
   dpw_msg_type   rsp_reg;
   logic          rsp_valid_reg;
   dpw_drive_type drive_reg;
   logic          persist_reg;

   assign prdata      = prdata_reg;
   assign pready      = pready_reg;
   assign pslverr     = pslverr_reg;
   assign rsp         = rsp_reg;
   assign rsp_valid   = rsp_valid_reg;
   assign drive       = drive_reg;
   assign persist_req = persist_reg;

   //----------------------------------------
   // APB decode
   //----------------------------------------
   logic        apb_do;
   logic        apb_wr;
   logic [2:0]  slot;
   logic        in_attr;
   logic        in_val;
   logic        in_err;
   logic        hit_map;
   logic [31:0] rd_word;

   // One wait state keeps read data on a flip-flop
   assign apb_do  = psel && penable && !pready_reg;
   assign apb_wr  = apb_do && pwrite;
   assign slot    = paddr[4:2];
   assign in_attr = (paddr[7:5] == 3'h1) && (paddr[1:0] == 2'h0);
   assign in_val  = (paddr[7:5] == 3'h2) && (paddr[1:0] == 2'h0);
   assign in_err  = (paddr[7:5] == 3'h3) && (paddr[1:0] == 2'h0);

   always_comb begin
      hit_map = 1'b1;
      rd_word = 32'h0000_0000;
      if (paddr == `DPW_CTRL_OFS) begin
         rd_word = ctrl_reg;
      end else if (paddr == `DPW_STATUS_OFS) begin
         rd_word = {16'h0000, status_reg};
      end else if (paddr == `DPW_FREQ_OFS) begin
         rd_word = {16'h0000, freq_reg};
      end else if (paddr == `DPW_SEEN_OFS) begin
         rd_word = {ref_reg, cw_reg};
      end else if (paddr == `DPW_DRIVE_OFS) begin
         rd_word = {16'h0000, drive_reg};
      end else if (paddr == `DPW_LAST_OFS) begin
         rd_word = {lexp_reg, 4'h0, ltype_reg, 5'h00, lnum_reg};
      end else if (in_attr) begin
         rd_word = attr_reg[slot];
      end else if (in_val) begin
         rd_word = pval_reg[slot];
      end else if (in_err) begin
         rd_word = {24'h000000, err_reg[slot]};
      end else begin
         hit_map = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= apb_do;
         prdata_reg  <= (apb_do && !pwrite) ? rd_word : 32'h0000_0000;
         pslverr_reg <= apb_do && !hit_map;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg   <= `DPW_CTRL_RST;
         status_reg <= 16'h0000;
         freq_reg   <= 16'h0000;
      end else if (apb_wr) begin
         if (paddr == `DPW_CTRL_OFS) begin
            ctrl_reg <= pwdata;
         end else if (paddr == `DPW_STATUS_OFS) begin
            status_reg <= pwdata[15:0];
         end else if (paddr == `DPW_FREQ_OFS) begin
            freq_reg <= pwdata[15:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NP; i++) begin
            attr_reg[i] <= '0;
            err_reg[i]  <= 8'h00;
         end
      end else if (apb_wr && in_attr) begin
         attr_reg[slot] <= pwdata;
      end else if (apb_wr && in_err) begin
         err_reg[slot] <= pwdata[7:0];
      end
   end

   //----------------------------------------
   // Parameter lookup
   //----------------------------------------
   logic [3:0]   cmd;
   logic [10:0]  param_number_field;
   logic [7:0]   sub;
   logic         hit;
   logic [2:0]   hit_idx;
   dpw_attr_type hattr;
   logic         is_dword;

   assign cmd = msg_reg.key[15:12];
   assign param_number_field = msg_reg.key[10:0];
   assign sub = msg_reg.idx[7:0];

   always_comb begin
      hit     = 1'b0;
      hit_idx = 3'h0;
      for (int i = NP - 1; i >= 0; i--) begin
         if (attr_reg[i].num == param_number_field) begin
            hit     = 1'b1;
            hit_idx = 3'(i);
         end
      end
   end

   assign hattr    = attr_reg[hit_idx];
   assign is_dword = (hattr.dtype == `DPW_T_S32) || (hattr.dtype == `DPW_T_U32);

   //----------------------------------------
   // Command execution
   //----------------------------------------
   dpw_msg_type rsp_next;
   logic        wr_en;
   logic        ee_en;
   logic        err_rd;
   logic        sub_ok;
   logic [7:0]  err_val;
   logic        txt_rd;
   logic        txt_wr;

   assign err_rd  = (param_number_field == `DPW_ERR_PARAM);
   // Array element 1 sits in slot 0; the high index byte is ignored
   assign sub_ok  = (sub != 8'h00) && (sub <= 8'(NP));
   assign err_val = err_reg[3'(sub - 8'h01)];
   assign txt_rd  = (sub == `DPW_TXT_RD_CHAR);
   assign txt_wr  = (sub == `DPW_TXT_WR_CHAR);

   always_comb begin
      rsp_next     = '0;
      rsp_next.idx = msg_reg.idx;
      rsp_next.len = `DPW_LEN_PARAM;
      rsp_next.pw1 = status_reg;
      rsp_next.pw2 = freq_reg;
      wr_en        = 1'b0;
      ee_en        = 1'b0;
      rsp_next.key = {`DPW_RSP_FAIL, 1'b0, param_number_field};
      rsp_next.val = `DPW_F_NO_PARAM;
      case (cmd)
         `DPW_CMD_NONE: begin
            rsp_next.key = {4'h0, 1'b0, param_number_field};
         end
         `DPW_CMD_READ: begin
            if (err_rd) begin
               // Fault codes outside 1..99 are treated as a missing element
               if (sub_ok && err_val != 8'h00 && err_val <= `DPW_ERR_MAX) begin
                  rsp_next.key = {`DPW_RSP_WORD, 1'b0, param_number_field};
                  rsp_next.val = {24'h000000, err_val};
               end else begin
                  rsp_next.val = `DPW_F_NO_INDEX;
               end
            end else if (hit) begin
               rsp_next.key = {is_dword ? `DPW_RSP_DWORD : `DPW_RSP_WORD, 1'b0, param_number_field};
               rsp_next.val = pval_reg[hit_idx];
            end
         end
         `DPW_CMD_WR_W, `DPW_CMD_EE_W: begin
            if (!hit) begin
               rsp_next.val = `DPW_F_NO_PARAM;
            end else if (!hattr.wr) begin
               rsp_next.val = `DPW_F_NO_WRITE;
            end else if (is_dword || hattr.dtype == `DPW_T_TEXT) begin
               rsp_next.val = `DPW_F_TYPE;
            end else if (hattr.dtype == `DPW_T_U8 && msg_reg.val[31:8] != 24'h0) begin
               rsp_next.val = `DPW_F_LIMIT;
            end else begin
               wr_en        = 1'b1;
               ee_en        = (cmd == `DPW_CMD_EE_W);
               rsp_next.key = {`DPW_RSP_WORD, 1'b0, param_number_field};
               rsp_next.val = msg_reg.val;
            end
         end
         `DPW_CMD_WR_D, `DPW_CMD_EE_D: begin
            if (!hit) begin
               rsp_next.val = `DPW_F_NO_PARAM;
            end else if (!hattr.wr) begin
               rsp_next.val = `DPW_F_NO_WRITE;
            end else if (!is_dword) begin
               rsp_next.val = `DPW_F_TYPE;
            end else begin
               wr_en        = 1'b1;
               ee_en        = (cmd == `DPW_CMD_EE_D);
               rsp_next.key = {`DPW_RSP_DWORD, 1'b0, param_number_field};
               rsp_next.val = msg_reg.val;
            end
         end
         `DPW_CMD_TEXT: begin
            if (!hit) begin
               rsp_next.val = `DPW_F_NO_PARAM;
            end else if (hattr.dtype != `DPW_T_TEXT) begin
               rsp_next.val = `DPW_F_TYPE;
            end else if (txt_rd || (txt_wr && hattr.wr)) begin
               // Only the text length is held; characters pass elsewhere
               wr_en        = txt_wr;
               rsp_next.key = {`DPW_CMD_TEXT, 1'b0, param_number_field};
               rsp_next.val = txt_wr ? msg_reg.val : pval_reg[hit_idx];
               rsp_next.len = `DPW_LEN_TEXT_FIX + rsp_next.val[7:0];
            end else begin
               rsp_next.val = txt_wr ? `DPW_F_NO_WRITE : `DPW_F_NO_INDEX;
            end
         end
         default: begin
            rsp_next.key = {4'h0, 1'b0, param_number_field};
         end
      endcase
   end

   //----------------------------------------
   // Message sequencing
   //----------------------------------------
   logic accept;
   logic len_ok;
   logic drive_prof;

   assign len_ok     = (msg_in.key[15:12] == `DPW_CMD_TEXT) ?
                       (msg_in.len >= `DPW_LEN_TEXT_FIX) :
                       (msg_in.len == `DPW_LEN_PARAM);
   assign accept     = (state_reg == ST_IDLE) && msg_valid && msg_ok && len_ok;
   assign drive_prof = (ctrl_reg[`DPW_PROFILE_LSB +: 8] == `DPW_PROFILE_DRIVE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         msg_reg   <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (accept) begin
                  msg_reg   <= msg_in;
                  state_reg <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               state_reg <= ST_REPLY;
            end
            ST_REPLY: begin
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsp_reg       <= '0;
         rsp_valid_reg <= 1'b0;
         persist_reg   <= 1'b0;
         ltype_reg     <= 4'h0;
         lnum_reg      <= 11'h000;
         lexp_reg      <= 8'h00;
      end else begin
         rsp_valid_reg <= (state_reg == ST_EXEC);
         persist_reg   <= (state_reg == ST_EXEC) && ee_en;
         if (state_reg == ST_EXEC) begin
            rsp_reg   <= rsp_next;
            ltype_reg <= hattr.dtype;
            lnum_reg  <= param_number_field;
            // Decimal exponent of the factor; index 73 shares 0.1
            lexp_reg  <= (hattr.conv == `DPW_CONV_SPECIAL) ? 8'hff : hattr.conv;
         end
      end
   end

   // Message writes land after bus writes so a clash keeps the message value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NP; i++) begin
            pval_reg[i] <= 32'h0000_0000;
         end
      end else begin
         if (apb_wr && in_val) begin
            pval_reg[slot] <= pwdata;
         end
         if (state_reg == ST_EXEC && wr_en) begin
            pval_reg[hit_idx] <= msg_reg.val;
         end
      end
   end

   //----------------------------------------
   // Process words and control word
   //----------------------------------------
   logic cw_take;

   // Bit 10 low leaves the previous control word in force
   assign cw_take = (state_reg == ST_EXEC) && drive_prof && msg_reg.pw1[10];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cw_reg       <= `DPW_CW_RST;
         ref_reg      <= 16'h0000;
         cw7_prev_reg <= 1'b0;
      end else begin
         cw7_prev_reg <= cw_reg[7];
         if (cw_take) begin
            cw_reg  <= msg_reg.pw1;
            ref_reg <= msg_reg.pw2;
         end
      end
   end

   // Selection: 0 input only, 1 serial only, 2 both, 3 either
   function automatic logic gate_sel(input logic [1:0] sel, input logic ser,
                                     input logic dig);
      case (sel)
         2'h0:    gate_sel = dig;
         2'h1:    gate_sel = ser;
         2'h2:    gate_sel = ser & dig;
         default: gate_sel = ser | dig;
      endcase
   endfunction : gate_sel

   logic [1:0] sel_pre;
   logic [1:0] sel_dc;
   logic [1:0] sel_co;

   assign sel_pre = ctrl_reg[`DPW_SEL_PRE_LSB +: 2];
   assign sel_dc  = ctrl_reg[`DPW_SEL_DC_LSB +: 2];
   assign sel_co  = ctrl_reg[`DPW_SEL_CO_LSB +: 2];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_reg <= '0;
      end else begin
         drive_reg.preset[0]  <= gate_sel(sel_pre, cw_reg[0], din_preset[0]);
         drive_reg.preset[1]  <= gate_sel(sel_pre, cw_reg[1], din_preset[1]);
         drive_reg.dc_brake   <= gate_sel(sel_dc, !cw_reg[2], din_dc_brake);
         drive_reg.coast      <= gate_sel(sel_co, !cw_reg[3], din_coast);
         drive_reg.quick_stop <= !cw_reg[4];
         drive_reg.freeze     <= !cw_reg[5];
         drive_reg.ramp_run   <= cw_reg[6];
         drive_reg.trip_reset <= cw_reg[7] && !cw7_prev_reg;
         drive_reg.jog        <= cw_reg[8];
         drive_reg.ramp2      <= cw_reg[9];
         drive_reg.data_valid <= cw_reg[10];
         drive_reg.relay      <= cw_reg[11];
         drive_reg.dout       <= cw_reg[12];
         drive_reg.setup      <= cw_reg[14:13];
         drive_reg.reverse    <= cw_reg[15];
      end
   end

   //----------------------------------------
   // Checks
   //----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_accept;
      accept;
   endsequence

   sequence s_reply;
      ##1 !rsp_valid ##1 rsp_valid ##1 !rsp_valid;
   endsequence

   a_reply_follows: assert property (s_accept |-> s_reply)
      else $error("reply not two cycles after accepted message");
   a_bad_ignored: assert property (
      state_reg == ST_IDLE && msg_valid && !msg_ok |=> state_reg == ST_IDLE)
      else $error("unchecked message was acted on");
   a_read_value: assert property (
      state_reg == ST_EXEC && cmd == `DPW_CMD_READ && hit && !err_rd
      |=> rsp.val == $past(pval_reg[hit_idx]) && rsp.key[15:12] != `DPW_RSP_FAIL)
      else $error("read reply lacks present value");
   a_err_range: assert property (
      rsp_valid && rsp.key[10:0] == `DPW_ERR_PARAM && rsp.key[15:12] == `DPW_RSP_WORD
      |-> rsp.val != 32'h0 && rsp.val <= 32'h63)
      else $error("fault code outside 1 to 99");
   a_text_type: assert property (
      rsp_valid && rsp.key[15:12] == `DPW_CMD_TEXT |-> ltype_reg == `DPW_T_TEXT)
      else $error("text reply for non-text parameter");
   a_param_len: assert property (
      rsp_valid && rsp.key[15:12] != `DPW_CMD_TEXT |-> rsp.len == `DPW_LEN_PARAM)
      else $error("parameter reply length wrong");
   a_profile_gate: assert property (
      state_reg == ST_EXEC && !drive_prof |=> $stable(cw_reg))
      else $error("control word taken under other profile");
   a_preset_sel: assert property (
      sel_pre == 2'h1 && $stable(sel_pre) |=> drive.preset == $past(cw_reg[1:0]))
      else $error("preset select does not follow control word");
   a_coast_stop: assert property (
      sel_co == 2'h1 && !cw_reg[3] |=> drive.coast)
      else $error("coast not driven by bit 03");
   a_quick_stop: assert property (!cw_reg[4] |=> drive.quick_stop)
      else $error("quick stop not driven by bit 04");

endmodule : dpw_decoder

//--- dpw_decoder_tb_top.sv
`timescale 1ns/10ps
`include "dpw_regs.svh"
module dpw_decoder_tb_top
   import dpw_pkg::*;
;
   typedef struct packed {
      logic [15:0] key;
      logic [15:0] idx;
      logic [31:0] val;
      logic        ck;
      logic [3:0]  code;
      logic [31:0] rv;
      logic        per;
   } dpw_row_type;
   localparam dpw_row_type ROWS [0:8] = '{
      '{16'h10cf, 16'h0000, 32'h0,   1'b1, 4'h1, 32'h64,  1'b0},
      '{16'h20cf, 16'h0000, 32'h3e8, 1'b1, 4'h1, 32'h3e8, 1'b0},
      '{16'h10cf, 16'h0000, 32'h0,   1'b1, 4'h1, 32'h3e8, 1'b0},
      '{16'he0cf, 16'h0000, 32'h14,  1'b1, 4'h1, 32'h14,  1'b1},
      '{16'h17ff, 16'h0000, 32'h0,   1'b1, 4'h7, 32'h0,   1'b0},
      '{16'h1267, 16'h0101, 32'h0,   1'b1, 4'h1, 32'h5,   1'b0},
      '{16'h1267, 16'h0000, 32'h0,   1'b1, 4'h7, 32'h3,   1'b0},
      '{16'hf0cf, 16'h0004, 32'h0,   1'b1, 4'h7, 32'h5,   1'b0},
      '{16'hf26d, 16'h0004, 32'h0,   1'b1, 4'hf, 32'h5,   1'b0}};
   logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]    paddr = 0;
   logic [31:0]   pwdata = 0, prdata, rd;
   logic          pready, pslverr, err, rsp_valid, persist_req, got, pq, go = 0, ok = 0;
   logic [1:0]    dinp = 2'b01;
   logic          dind = 0, dinc = 0;
   dpw_msg_type   msg_in, rsp, req = '0;
   logic          msg_valid, msg_ok;
   dpw_drive_type drive;
   int            n_mismatch = 0, tests_run = 0;
   always #50 pclk = ~pclk;
   dpw_master_model partner (.pclk(pclk), .go(go), .ok(ok), .req(req),
      .msg_in(msg_in), .msg_valid(msg_valid), .msg_ok(msg_ok));
   dpw_decoder uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .msg_in(msg_in), .msg_valid(msg_valid),
      .msg_ok(msg_ok), .din_preset(dinp), .din_dc_brake(dind), .din_coast(dinc),
      .rsp(rsp), .rsp_valid(rsp_valid), .drive(drive), .persist_req(persist_req));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // The wait ends on pready; only the watchdog ends a hung wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb
   task msg(input logic [15:0] k, i, input logic [31:0] v, input logic [15:0] p1,
            input logic o);
      int n;
      req <= '{(k[15:12] == 4'hf) ? 8'h0a : 8'h0e, k, i, v, p1, 16'h0};
      ok <= o;
      go <= 1;
      @(posedge pclk);
      go <= 0;
      got = 0;
      for (n = 0; n < 8 && !got; n++) begin
         @(posedge pclk);
         got = (rsp_valid === 1'b1);
         // Persist request is a pulse beside the reply; take it there
         pq = (persist_req === 1'b1);
      end
      @(posedge pclk);
      @(posedge pclk);
   endtask : msg
   task end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_of_test
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      #100000;
      n_mismatch++;
      end_of_test;
   end
   initial begin
      repeat (5) @(posedge pclk);
      chk({16'h0, drive}, 32'h0);
      presetn <= 1;
      @(posedge pclk);
      apb(0, `DPW_CTRL_OFS, 0);
      chk(rd, `DPW_CTRL_RST);
      chk({16'h0, drive}, 32'h4000);
      apb(0, 8'h18, 0);
      chk({31'h0, err}, 32'h1);
      apb(1, `DPW_ATTR_BASE, 32'h0016_00cf);
      apb(1, `DPW_VAL_BASE, 32'h64);
      apb(1, `DPW_ERR_BASE, 32'h5);
      apb(1, `DPW_ATTR_BASE + 8'h04, 32'h0009_026d);
      apb(1, `DPW_VAL_BASE + 8'h04, 32'h5);
      apb(1, `DPW_STATUS_OFS, 32'h0a5c);
      apb(1, `DPW_FREQ_OFS, 32'h1234);
      $display("reset and register tests done");
      for (int r = 0; r < 9; r++) begin
         msg(ROWS[r].key, ROWS[r].idx, ROWS[r].val, 16'h0, 1);
         chk({31'h0, got}, 32'h1);
         if (ROWS[r].ck)
            chk({28'h0, rsp.key[15:12]}, {28'h0, ROWS[r].code});
         chk(rsp.val, ROWS[r].rv);
         chk({31'h0, pq}, {31'h0, ROWS[r].per});
         $display("row %0d done", r);
      end
      chk({rsp.pw1, rsp.pw2}, 32'h0a5c_1234);
      chk({24'h0, rsp.len}, 32'h0000_000f);
      msg(16'h10cf, 0, 0, 16'h0, 0);
      chk({31'h0, got}, 32'h0);
      apb(1, `DPW_CTRL_OFS, 32'h1501);
      msg(16'h0, 0, 0, 16'h0403, 1);
      chk({26'h0, drive[15:10]}, 32'h3f);
      chk({31'h0, drive.data_valid}, 32'h1);
      msg(16'h0, 0, 0, 16'h043e, 1);
      chk({26'h0, drive[15:10]}, 32'h20);
      apb(1, `DPW_CTRL_OFS, 32'h3a01);
      dinp <= 2'b11;
      msg(16'h0, 0, 0, 16'h0401, 1);
      chk({26'h0, drive[15:10]}, 32'h17);
      apb(1, `DPW_CTRL_OFS, 32'h1500);
      msg(16'h0, 0, 0, 16'h0403, 1);
      chk({26'h0, drive[15:10]}, 32'h1f);
      $display("control word tests done");
      presetn <= 0;
      @(posedge pclk);
      chk({16'h0, drive}, 32'h0);
      presetn <= 1;
      @(posedge pclk);
      apb(0, `DPW_SEEN_OFS, 0);
      chk(rd, 32'h0000_003c);
      chk({16'h0, drive}, 32'hc000);
      $display("mid-run reset test done");
      end_of_test;
   end
endmodule : dpw_decoder_tb_top

//--- dpw_master_model.sv
`timescale 1ns/10ps
module dpw_master_model
   import dpw_pkg::*;
(
   // Clock
   input  wire logic        pclk,
   // Requests from the bench
   input  wire logic        go,
   input  wire logic        ok,
   input  wire dpw_msg_type req,
   // Framed message towards the decoder
   output dpw_msg_type      msg_in,
   output logic             msg_valid,
   output logic             msg_ok
);
   // ----------------------------------------
   // Framing side
   // ----------------------------------------
   // Fields are not held outside the pulse: a late sample sees inverted data
   always_ff @(posedge pclk) begin
      msg_valid <= go;
      msg_ok    <= go & ok;
      msg_in    <= go ? req : ~req;
   end
endmodule : dpw_master_model

//--- dpw_pkg.sv
package dpw_pkg;
   typedef struct packed {
      logic [7:0]  len;
      logic [15:0] key;
      logic [15:0] idx;
      logic [31:0] val;
      logic [15:0] pw1;
      logic [15:0] pw2;
   } dpw_msg_type;
   typedef struct packed {
      logic [1:0] preset;
      logic       dc_brake;
      logic       coast;
      logic       quick_stop;
      logic       freeze;
      logic       ramp_run;
      logic       trip_reset;
      logic       jog;
      logic       ramp2;
      logic       relay;
      logic       dout;
      logic [1:0] setup;
      logic       reverse;
      logic       data_valid;
   } dpw_drive_type;
   typedef struct packed {
      logic [7:0]  conv;
      logic [2:0]  spare;
      logic        wr;
      logic [3:0]  dtype;
      logic [4:0]  pad;
      logic [10:0] num;
   } dpw_attr_type;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_EXEC  = 3'b010,
      ST_REPLY = 3'b100
   } dpw_state_type;
endpackage : dpw_pkg

//--- dpw_regs.svh
`ifndef DPW_REGS_SVH
`define DPW_REGS_SVH
// APB byte offsets
`define DPW_CTRL_OFS      8'h00
`define DPW_STATUS_OFS    8'h04
`define DPW_FREQ_OFS      8'h08
`define DPW_SEEN_OFS      8'h0c
`define DPW_DRIVE_OFS     8'h10
`define DPW_LAST_OFS      8'h14
`define DPW_ATTR_BASE     8'h20
`define DPW_VAL_BASE      8'h40
`define DPW_ERR_BASE      8'h60
`define DPW_NUM_PARAMS    8
// Control register fields
`define DPW_PROFILE_LSB   0
`define DPW_SEL_PRE_LSB   8
`define DPW_SEL_DC_LSB    10
`define DPW_SEL_CO_LSB    12
`define DPW_CTRL_RST      32'h0000_0000
`define DPW_PROFILE_DRIVE 8'h01
// Command and response codes
`define DPW_CMD_NONE      4'h0
`define DPW_CMD_READ      4'h1
`define DPW_CMD_WR_W      4'h2
`define DPW_CMD_WR_D      4'h3
`define DPW_CMD_EE_D      4'hd
`define DPW_CMD_EE_W      4'he
`define DPW_CMD_TEXT      4'hf
`define DPW_RSP_WORD      4'h1
`define DPW_RSP_DWORD     4'h2
`define DPW_RSP_FAIL      4'h7
// Fault numbers
`define DPW_F_NO_PARAM    32'h0000_0000
`define DPW_F_NO_WRITE    32'h0000_0001
`define DPW_F_LIMIT       32'h0000_0002
`define DPW_F_NO_INDEX    32'h0000_0003
`define DPW_F_TYPE        32'h0000_0005
// Data types and special values
`define DPW_T_S16         4'h3
`define DPW_T_S32         4'h4
`define DPW_T_U8          4'h5
`define DPW_T_U16         4'h6
`define DPW_T_U32         4'h7
`define DPW_T_TEXT        4'h9
`define DPW_CONV_SPECIAL  8'h49
`define DPW_ERR_PARAM     11'h267
`define DPW_ERR_MAX       8'h63
`define DPW_TXT_RD_CHAR   8'h04
`define DPW_TXT_WR_CHAR   8'h05
`define DPW_LEN_PARAM     8'h0e
`define DPW_LEN_TEXT_FIX  8'h0a
`define DPW_CW_RST        16'h003c
`endif
